// >>> core/logic_or_xor_datapath.sv
// OR/XOR execute datapath: combines working_register with a memory byte,
// an immediate or an I/O register and writes the result back.
// Assumes the decoder presents one operation per cycle as a one-cycle pulse
// and that the memory/IO buses take writes on the cycle after.
//
// Overview of operation
// - OR memory into working register, zero flag
// - OR into memory byte, zero flag
// - XOR immediate into working register, zero flag
// - XOR into I/O register, zero flag

`timescale 1ns/10ps
`default_nettype none

module logic_or_xor_datapath
	import logic_or_xor_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rst_n,
	input  wire logic              opValid,
	input  wire logic_op_e         opCode,
	input  wire logic [DATA_W-1:0] memData,
	input  wire logic [DATA_W-1:0] immData,
	input  wire logic [DATA_W-1:0] ioData,
	input  wire logic              carryIn,
	input  wire logic              halfCarryIn,
	input  wire logic              signedWrapIn,
	output logic [DATA_W-1:0]      workingRegister,
	output logic                   resultNilFlag,
	output logic                   carryFlag,
	output logic                   halfCarryFlag,
	output logic                   signedWrapFlag,
	output logic                   memWrite,
	output logic [DATA_W-1:0]      memWriteData,
	output logic                   ioWrite,
	output logic [DATA_W-1:0]      ioWriteData
);

	// ****************************************
	// Operation decode
	// ****************************************

	// One decode shared by all strobes, so the qualifier cannot drift
	function automatic logic opIs(
		input logic      valid,
		input logic_op_e code,
		input logic_op_e want
	);
		return valid && (code == want);
	endfunction

	wire logic isOrWork;
	wire logic isOrMem;
	wire logic isXorImm;
	wire logic isXorIo;
	wire logic anyOp;
	wire logic writesWork;

	assign isOrWork   = opIs(opValid, opCode, OP_OR_TO_WORK);
	assign isOrMem    = opIs(opValid, opCode, OP_OR_TO_MEM);
	assign isXorImm   = opIs(opValid, opCode, OP_XOR_IMM);
	assign isXorIo    = opIs(opValid, opCode, OP_XOR_TO_IO);

	// OP_NONE and idle cycles fall out here
	assign anyOp      = isOrWork || isOrMem || isXorImm || isXorIo;

	// Only two forms land in the working register
	assign writesWork = isOrWork || isXorImm;

	// ****************************************
	// Bit lanes
	// ****************************************

	wire logic [DATA_W-1:0] orMem;
	wire logic [DATA_W-1:0] xorImm;
	wire logic [DATA_W-1:0] xorIo;
	wire logic [DATA_W-1:0] result;

	// Lanes are independent: no carry chain, nothing to disturb other flags
	genvar lane;
	generate
		for (lane = 0; lane < DATA_W; lane++) begin : gen_lane
			assign orMem[lane]  = workingRegister[lane] | memData[lane];
			assign xorImm[lane] = workingRegister[lane] ^ immData[lane];
			assign xorIo[lane]  = workingRegister[lane] ^ ioData[lane];
			assign result[lane] = isXorImm ? xorImm[lane] : (isXorIo ? xorIo[lane] : orMem[lane]);
		end : gen_lane
	endgenerate

	// ****************************************
	// Zero detect
	// ****************************************

	wire logic [DATA_W:0] anyOne;
	wire logic            resultZero;

	assign anyOne[0] = 1'b0;

	generate
		for (lane = 0; lane < DATA_W; lane++) begin : gen_zero
			assign anyOne[lane+1] = anyOne[lane] | result[lane];
		end : gen_zero
	endgenerate

	assign resultZero = ~anyOne[DATA_W];

	// ****************************************
	// Next-state values
	// ****************************************

	wire logic [DATA_W-1:0] next_workingRegister;
	wire logic              next_resultNilFlag;
	wire logic              next_carryFlag;
	wire logic              next_halfCarryFlag;
	wire logic              next_signedWrapFlag;
	wire logic [DATA_W-1:0] next_memWriteData;
	wire logic [DATA_W-1:0] next_ioWriteData;

	assign next_workingRegister = writesWork ? result : workingRegister;

	assign next_resultNilFlag   = anyOp ? resultZero : resultNilFlag;

	// Core flags reload only outside logic ops; that is what preserves them
	assign next_carryFlag       = anyOp ? carryFlag : carryIn;
	assign next_halfCarryFlag   = anyOp ? halfCarryFlag : halfCarryIn;
	assign next_signedWrapFlag  = anyOp ? signedWrapFlag : signedWrapIn;

	// Write data holds until the next op of its own kind
	assign next_memWriteData    = isOrMem ? orMem : memWriteData;
	assign next_ioWriteData     = isXorIo ? xorIo : ioWriteData;

	// ****************************************
	// Working register and flags
	// ****************************************

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			workingRegister <= WORK_RESET;
		end else begin
			workingRegister <= next_workingRegister;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			resultNilFlag <= FLAG_RESET;
		end else begin
			resultNilFlag <= next_resultNilFlag;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			carryFlag <= FLAG_RESET;
		end else begin
			carryFlag <= next_carryFlag;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			halfCarryFlag <= FLAG_RESET;
		end else begin
			halfCarryFlag <= next_halfCarryFlag;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			signedWrapFlag <= FLAG_RESET;
		end else begin
			signedWrapFlag <= next_signedWrapFlag;
		end
	end

	// ****************************************
	// Memory and I/O write-back
	// ****************************************

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			memWrite <= 1'b0;
		end else begin
			memWrite <= isOrMem;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			memWriteData <= ZERO_BYTE;
		end else begin
			memWriteData <= next_memWriteData;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ioWrite <= 1'b0;
		end else begin
			ioWrite <= isXorIo;
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ioWriteData <= ZERO_BYTE;
		end else begin
			ioWriteData <= next_ioWriteData;
		end
	end

endmodule // logic_or_xor_datapath

`default_nettype wire

// >>> core/logic_or_xor_pkg.sv
// Constants for the OR/XOR execute datapath.
// Assumes an 8-bit core with a single system clock.

package logic_or_xor_pkg;

	localparam int DATA_W = 8;

	// Operation select codes from the decoder
	typedef enum logic [2:0] {
		OP_NONE,
		OP_OR_TO_WORK,
		OP_OR_TO_MEM,
		OP_XOR_IMM,
		OP_XOR_TO_IO
	} logic_op_e;

	localparam logic [DATA_W-1:0] WORK_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_BYTE   = 8'h00;
	localparam logic              FLAG_RESET  = 1'b0;

endpackage : logic_or_xor_pkg

// >>> sim/logic_or_xor_asserts.sv
// Port checker for the OR/XOR datapath
// Bound to the datapath, sees its ports only
`timescale 1ns/10ps
`default_nettype none
module logic_or_xor_asserts import logic_or_xor_pkg::*; (input wire logic mclk, rst_n, opValid, carryFlag,
	input wire logic_op_e opCode, input wire logic [7:0] memData, immData, ioData, workingRegister,
	input wire logic [7:0] memWriteData, ioWriteData, input wire logic resultNilFlag, memWrite, ioWrite,
	input wire logic halfCarryFlag, signedWrapFlag);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_or_work: assert property (opValid && opCode == OP_OR_TO_WORK |=>
		workingRegister == ($past(workingRegister) | $past(memData))) else $error("or work");
	a_or_mem: assert property (opValid && opCode == OP_OR_TO_MEM |=> memWrite &&
		memWriteData == ($past(workingRegister) | $past(memData))) else $error("or mem");
	a_xor_imm: assert property (opValid && opCode == OP_XOR_IMM |=>
		workingRegister == ($past(workingRegister) ^ $past(immData))) else $error("xor imm");
	a_xor_io: assert property (opValid && opCode == OP_XOR_TO_IO |=> ioWrite &&
		ioWriteData == ($past(workingRegister) ^ $past(ioData))) else $error("xor io");
	a_nil_flag: assert property (opValid && opCode != OP_NONE |=> resultNilFlag ==
		((memWrite ? memWriteData : ioWrite ? ioWriteData : workingRegister) == 8'h00)) else $error("nil");
	a_carry_kept: assert property (opValid && opCode != OP_NONE |=> $stable(carryFlag)) else $error("carry");
	a_half_kept: assert property (opValid && opCode != OP_NONE |=> $stable(halfCarryFlag)) else $error("half");
	a_wrap_kept: assert property (opValid && opCode != OP_NONE |=> $stable(signedWrapFlag)) else $error("wrap");
	c_mem: cover property (memWrite);
	c_io: cover property (ioWrite);
	c_nil: cover property (resultNilFlag);
endmodule // logic_or_xor_asserts
bind logic_or_xor_datapath logic_or_xor_asserts chk (.*);
`default_nettype wire

// >>> sim/logic_or_xor_datapath_tb.sv
// Random and corner ops through the OR/XOR datapath
// Store model supplies the memory and I/O bytes
`timescale 1ns/10ps
`default_nettype none
module logic_or_xor_datapath_tb import logic_or_xor_pkg::*;;
	logic mclk = 0, rst_n = 0, opValid = 0, cIn = 0, ec, mw, iw, nil, cf;
	logic hIn = 0, sIn = 0, eh, es, hf, sf;
	logic_op_e op = OP_NONE;
	logic [7:0] imm = 0, w, md, id, mwd, iwd, r, ew = 0, em = 8'h5A, ei = 8'hC3;
	int num_errors = 0, n_checks = 0;
	always #25 mclk = ~mclk;
	operand_store ps (.mclk, .mw, .iw, .mwd, .iwd, .md, .id);
	logic_or_xor_datapath dut (.mclk, .rst_n, .opValid, .opCode(op), .memData(md), .immData(imm), .ioData(id),
		.carryIn(cIn), .halfCarryIn(hIn), .signedWrapIn(sIn), .workingRegister(w), .resultNilFlag(nil),
		.carryFlag(cf), .halfCarryFlag(hf), .signedWrapFlag(sf), .memWrite(mw), .memWriteData(mwd), .ioWrite(iw),
		.ioWriteData(iwd));
	task stop_test();
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(string s, logic [7:0] e, g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	// Expected result from the tracked operands
	function logic [7:0] calc(logic_op_e o, logic [7:0] i);
		return o == OP_XOR_IMM ? ew ^ i : o == OP_XOR_TO_IO ? ew ^ ei : ew | em;
	endfunction
	task run(logic_op_e o, logic [7:0] i);
		@(posedge mclk);
		ec = cIn;
		eh = hIn;
		es = sIn;
		hIn <= 1'($urandom);
		sIn <= 1'($urandom);
		op <= o;
		imm <= i;
		opValid <= 1;
		cIn <= 1'($urandom);
		r = calc(o, i);
		@(posedge mclk);
		opValid <= 0;
		#1;
		case (o)
			OP_OR_TO_MEM: begin chk("mem", r, mwd); em = r; end
			OP_XOR_TO_IO: begin chk("io", r, iwd); ei = r; end
			default: begin chk("work", r, w); ew = r; end
		endcase
		chk("nil", 8'(r == 8'h00), 8'(nil));
		chk("carry", 8'(ec), 8'(cf));
		chk("half", 8'(eh), 8'(hf));
		chk("wrap", 8'(es), 8'(sf));
	endtask
	initial begin
		void'($urandom(58));
		repeat (8) @(posedge mclk);
		rst_n <= 1;
		run(OP_XOR_IMM, 8'h00);
		repeat (300) run(logic_op_e'($urandom_range(1, 4)), 8'($urandom));
		run(OP_XOR_IMM, ew);
		stop_test();
	end
	initial begin
		#100000;
		num_errors++;
		stop_test();
	end
endmodule // logic_or_xor_datapath_tb
`default_nettype wire

// >>> sim/operand_store.sv
// Memory byte and I/O register behind the datapath
// Takes write pulses one cycle after the op
`timescale 1ns/10ps
`default_nettype none
module operand_store (input wire logic mclk, mw, iw, input wire logic [7:0] mwd, iwd,
	output logic [7:0] md = 8'h5A, output logic [7:0] id = 8'hC3);
	always_ff @(posedge mclk) begin
		if (mw) md <= mwd;
		if (iw) id <= iwd;
	end
endmodule // operand_store
`default_nettype wire
